// File: mmuc_top.sv
`timescale 1ns/10ps
module mmuc_top
  import mmuc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // fetch unit
  input wire logic fetch_valid,
  input wire logic [TAG_W-1:0] fetch_va,
  input wire logic fetch_c,
  input wire logic fetch_miss,
  output logic itlb_hit,
  output logic [TAG_W-1:0] itlb_pa,
  output logic fetch_cacheable,
  output logic icache_fill,
  // load/store unit
  input wire mmuc_dacc_t dacc,
  input wire logic [TAG_W-1:0] data_va,
  input wire logic evict_dirty,
  output logic dtlb_hit,
  output logic [TAG_W-1:0] dtlb_pa,
  output mmuc_dpol_t dpol,
  output logic wb_write,
  // table walker
  input wire logic walk_fill,
  input wire logic walk_is_data,
  input wire logic [TAG_W-1:0] walk_va,
  input wire logic [TAG_W-1:0] walk_pa,
  input wire logic walk_fault,
  output logic prefetch_abort,
  output logic data_abort
);

  // byte strobes to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // fully associative search, live non-hole entries only
  function automatic logic [5:0] tlb_find(
    input mmuc_entry_t [ENTRIES-1:0] t,
    input logic [TAG_W-1:0] va
  );
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < ENTRIES; i++) begin
      if (t[i].valid && !t[i].hole && t[i].va == va) begin
        r = {1'b1, 5'(i)};
      end
    end
    tlb_find = r;
  endfunction

  // data attribute decode
  function automatic mmuc_dpol_t decode(
    input mmuc_dacc_t a,
    input logic mmu_on,
    input logic dc_on,
    input logic [1:0] md
  );
    mmuc_dpol_t p;
    logic x, c, b, ld;
    p = '0;
    // translation off reads as all attributes zero
    x = a.x & mmu_on;
    c = a.c & mmu_on;
    b = a.b & mmu_on;
    ld = !a.store || a.swap;
    p.coalesce = 1'b1;
    unique case ({x, c, b})
      3'b000: p.stall = 1'b1;
      3'b001: p.bufferable = 1'b1;
      3'b010: begin
        p.cacheable = 1'b1;
        p.bufferable = 1'b1;
      end
      3'b011: begin
        p.cacheable = 1'b1;
        p.bufferable = 1'b1;
        p.write_back = 1'b1;
      end
      3'b100: p.unpredictable = 1'b1;
      3'b101: begin
        p.bufferable = 1'b1;
        p.coalesce = 1'b0;
      end
      3'b110: begin
        p.mini = 1'b1;
        p.cacheable = 1'b1;
        p.bufferable = 1'b1;
        p.write_back = (md != MD_WT_RA);
        p.rw_alloc = (md == MD_WB_RWA);
      end
      3'b111: begin
        p.cacheable = 1'b1;
        p.bufferable = 1'b1;
        p.write_back = 1'b1;
        p.rw_alloc = 1'b1;
      end
    endcase
    if (!p.bufferable) begin
      p.coalesce = 1'b0;
    end
    // line fill on miss per allocation policy
    p.line_fill = a.valid && !a.hit && p.cacheable && dc_on &&
      (ld || (a.store && p.rw_alloc));
    // stores not held back by a write-back line go out
    p.ext_write = a.valid && a.store &&
      (!p.cacheable || !p.write_back || !dc_on);
    // fence cases, a swap fences if its load or store would
    p.fence = a.valid && ((ld && !c) || (a.store && x && !c && b) ||
      ({x, c, b} == 3'b000));
    decode = p;
  endfunction

  // register state
  logic [31:0] ctrl_reg;
  logic [31:0] va_reg;
  logic [31:0] pa_reg;
  logic [3:0] fault_reg;
  logic [3:0] fault_next;
  mmuc_entry_t [ENTRIES-1:0] tlb_reg [2];
  mmuc_entry_t [ENTRIES-1:0] tlb_next [2];
  logic [4:0] rr_reg [2];
  logic [4:0] rr_next [2];
  logic [4:0] lock_reg [2];
  logic [4:0] lock_next [2];
  // axi handshake state
  logic aw_held_reg, w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  // registered core-side outputs
  logic itlb_hit_reg, dtlb_hit_reg, fcache_reg, ifill_reg;
  logic [TAG_W-1:0] itlb_pa_reg, dtlb_pa_reg;
  mmuc_dpol_t dpol_reg;
  logic wb_write_reg, pabort_reg, dabort_reg;

  // control fields
  wire mmu_on = ctrl_reg[CTRL_MMU_BIT];
  wire align_on = ctrl_reg[CTRL_ALIGN_BIT];
  // dcache held off with translation off, in case software errs
  wire dc_on = ctrl_reg[CTRL_DC_BIT] & mmu_on;
  wire ic_on = ctrl_reg[CTRL_IC_BIT];
  wire [1:0] md = ctrl_reg[CTRL_MD_LSB +: 2];

  // write channel decode
  wire aw_take = s_axi_awvalid & awready_reg;
  wire w_take = s_axi_wvalid & wready_reg;
  wire aw_now = aw_held_reg | aw_take;
  wire w_now = w_held_reg | w_take;
  wire [7:0] wa = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wd = w_held_reg ? wdata_reg : s_axi_wdata;
  wire [3:0] ws = w_held_reg ? wstrb_reg : s_axi_wstrb;
  wire do_write = aw_now & w_now & !bvalid_reg;
  wire [31:0] wm = strb_mask(ws);
  wire wr_ctrl = do_write && wa == OFF_CTRL;
  wire wr_va = do_write && wa == OFF_TLB_VA;
  wire wr_pa = do_write && wa == OFF_TLB_PA;
  wire wr_cmd = do_write && wa == OFF_TLB_CMD && ws[0];
  wire wr_fault = do_write && wa == OFF_FAULT;
  wire wr_known = wa == OFF_CTRL || wa == OFF_TLB_VA ||
    wa == OFF_TLB_PA || wa == OFF_TLB_CMD || wa == OFF_FAULT ||
    wa == OFF_PTRS;
  wire [3:0] cmd = wd[3:0];
  wire bvalid_next = do_write | (bvalid_reg & !s_axi_bready);
  wire aw_held_next = aw_now & !do_write;
  wire w_held_next = w_now & !do_write;

  // read channel decode
  wire do_read = s_axi_arvalid & arready_reg;
  wire rvalid_next = do_read | (rvalid_reg & !s_axi_rready);
  wire rd_known = s_axi_araddr == OFF_CTRL ||
    s_axi_araddr == OFF_TLB_VA || s_axi_araddr == OFF_TLB_PA ||
    s_axi_araddr == OFF_TLB_CMD || s_axi_araddr == OFF_FAULT ||
    s_axi_araddr == OFF_PTRS;
  wire [31:0] ptrs_word = {9'h000, lock_reg[1], 3'h0, rr_reg[1],
    lock_reg[0], rr_reg[0]};
  wire [31:0] rd_word =
    s_axi_araddr == OFF_CTRL ? ctrl_reg :
    s_axi_araddr == OFF_TLB_VA ? va_reg :
    s_axi_araddr == OFF_TLB_PA ? pa_reg :
    s_axi_araddr == OFF_FAULT ? {28'h0000000, fault_reg} :
    s_axi_araddr == OFF_PTRS ? ptrs_word : 32'h00000000;

  // core-side lookups and decode
  wire [5:0] ifind = tlb_find(tlb_reg[0], fetch_va);
  wire [5:0] dfind = tlb_find(tlb_reg[1], data_va);
  wire fetch_c_eff = mmu_on ? fetch_c : 1'b1;
  mmuc_dpol_t dpol_now;
  assign dpol_now = decode(dacc, mmu_on, dc_on, md);
  wire misalign = dacc.valid && ((dacc.size == 2'h1 && dacc.addr_lo[0]) ||
    (dacc.size == 2'h2 && dacc.addr_lo != 2'h0));
  wire align_flt = misalign & align_on;
  wire walk_flt = walk_fault & mmu_on;
  wire lock_cmd = wr_cmd && (cmd == CMD_LOCK_I || cmd == CMD_LOCK_D);
  wire lock_flt = lock_cmd & pa_reg[PA_FAULT_BIT];

  // tlb maintenance, then hardware fill
  always_comb begin
    logic [4:0] idx;
    logic [5:0] f;
    logic sel;
    idx = 5'h00;
    f = 6'h00;
    sel = 1'b0;
    tlb_next = tlb_reg;
    rr_next = rr_reg;
    lock_next = lock_reg;
    if (wr_cmd) begin
      for (int t = 0; t < 2; t++) begin
        // global invalidate keeps locked slots
        if (cmd == CMD_INV_BOTH || cmd == 4'(CMD_INV_I + t)) begin
          for (int i = 0; i < ENTRIES; i++) begin
            if (!tlb_reg[t][i].locked) begin
              tlb_next[t][i].valid = 1'b0;
            end
          end
        end
        // entry invalidate, a locked hit becomes a hole
        if (cmd == 4'(CMD_INV_ENT_I + t)) begin
          f = tlb_find(tlb_reg[t], va_reg[31 -: TAG_W]);
          if (f[5] && tlb_reg[t][f[4:0]].locked) begin
            tlb_next[t][f[4:0]].hole = 1'b1;
          end else if (f[5]) begin
            tlb_next[t][f[4:0]].valid = 1'b0;
          end
        end
        // unlock frees every slot, holes are dropped
        if (cmd == 4'(CMD_UNLOCK_I + t)) begin
          for (int i = 0; i < ENTRIES; i++) begin
            if (tlb_reg[t][i].hole) begin
              tlb_next[t][i].valid = 1'b0;
            end
            tlb_next[t][i].locked = 1'b0;
            tlb_next[t][i].hole = 1'b0;
          end
          lock_next[t] = LOCK_RESET;
        end
        // lock at lock pointer, never in the last slot
        if (cmd == 4'(CMD_LOCK_I + t) && !pa_reg[PA_FAULT_BIT]) begin
          idx = lock_reg[t];
          tlb_next[t][idx].valid = 1'b1;
          tlb_next[t][idx].hole = 1'b0;
          tlb_next[t][idx].va = va_reg[31 -: TAG_W];
          tlb_next[t][idx].pa = pa_reg[31 -: TAG_W];
          tlb_next[t][idx].locked = (idx != LAST_ENTRY);
          if (idx != LAST_ENTRY) begin
            lock_next[t] = idx + 5'h01;
          end
          rr_next[t] = RR_RESET;
        end
      end
    end
    // walk fill at round-robin pointer, skipping locked slots
    if (walk_fill && !walk_fault) begin
      sel = walk_is_data;
      idx = rr_next[sel];
      tlb_next[sel][idx].valid = 1'b1;
      tlb_next[sel][idx].locked = 1'b0;
      tlb_next[sel][idx].hole = 1'b0;
      tlb_next[sel][idx].va = walk_va;
      tlb_next[sel][idx].pa = walk_pa;
      rr_next[sel] = (idx == LAST_ENTRY) ? lock_next[sel] :
        idx + 5'h01;
    end
  end

  // fault status, a new event wins over a clear
  always_comb begin
    fault_next = fault_reg;
    if (wr_fault) begin
      fault_next = fault_reg & ~wd[3:0] | fault_reg & ~wm[3:0];
    end
    if (align_flt) begin
      fault_next[FLT_ALIGN_BIT] = 1'b1;
    end
    if (walk_flt && !walk_is_data) begin
      fault_next[FLT_PREFETCH_BIT] = 1'b1;
    end
    if (walk_flt && walk_is_data) begin
      fault_next[FLT_DATA_BIT] = 1'b1;
    end
    if (lock_flt) begin
      fault_next[FLT_LOCK_BIT] = 1'b1;
    end
  end

  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      va_reg <= VA_RESET;
      pa_reg <= PA_RESET;
      fault_reg <= FAULT_RESET;
    end else begin
      ctrl_reg <= wr_ctrl ? (ctrl_reg & ~wm | wd & wm) & CTRL_MASK : ctrl_reg;
      va_reg <= wr_va ? (va_reg & ~wm | wd & wm) : va_reg;
      pa_reg <= wr_pa ? (pa_reg & ~wm | wd & wm) : pa_reg;
      fault_reg <= fault_next;
    end
  end

  // tlb contents and pointers, one generate slice per tlb
  for (genvar t = 0; t < 2; t++) begin : g_tlb
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        tlb_reg[t] <= '0;
        rr_reg[t] <= RR_RESET;
        lock_reg[t] <= LOCK_RESET;
      end else begin
        tlb_reg[t] <= tlb_next[t];
        rr_reg[t] <= rr_next[t];
        lock_reg[t] <= lock_next[t];
      end
    end
  end

  // axi write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= aw_take ? s_axi_awaddr : awaddr_reg;
      wdata_reg <= w_take ? s_axi_wdata : wdata_reg;
      wstrb_reg <= w_take ? s_axi_wstrb : wstrb_reg;
      awready_reg <= !aw_held_next & !bvalid_next;
      wready_reg <= !w_held_next & !bvalid_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= do_write ? (wr_known ? RESP_OKAY : RESP_SLVERR) :
        bresp_reg;
    end
  end

  // axi read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else begin
      arready_reg <= !rvalid_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= do_read ? rd_word : rdata_reg;
      rresp_reg <= do_read ? (rd_known ? RESP_OKAY : RESP_SLVERR) :
        rresp_reg;
    end
  end

  // core-side results, one cycle after the request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      itlb_hit_reg <= 1'b0;
      itlb_pa_reg <= '0;
      dtlb_hit_reg <= 1'b0;
      dtlb_pa_reg <= '0;
      fcache_reg <= 1'b0;
      ifill_reg <= 1'b0;
      dpol_reg <= '0;
      wb_write_reg <= 1'b0;
      pabort_reg <= 1'b0;
      dabort_reg <= 1'b0;
    end else begin
      itlb_hit_reg <= fetch_valid & ifind[5];
      itlb_pa_reg <= tlb_reg[0][ifind[4:0]].pa;
      dtlb_hit_reg <= dacc.valid & dfind[5];
      dtlb_pa_reg <= tlb_reg[1][dfind[4:0]].pa;
      fcache_reg <= fetch_valid & fetch_c_eff;
      ifill_reg <= fetch_valid & fetch_miss & fetch_c_eff & ic_on;
      dpol_reg <= dacc.valid ? dpol_now : '0;
      wb_write_reg <= evict_dirty;
      pabort_reg <= walk_flt & !walk_is_data;
      dabort_reg <= (walk_flt & walk_is_data) | align_flt | lock_flt;
    end
  end

  // output wiring
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign itlb_hit = itlb_hit_reg;
  assign itlb_pa = itlb_pa_reg;
  assign dtlb_hit = dtlb_hit_reg;
  assign dtlb_pa = dtlb_pa_reg;
  assign fetch_cacheable = fcache_reg;
  assign icache_fill = ifill_reg;
  assign dpol = dpol_reg;
  assign wb_write = wb_write_reg;
  assign prefetch_abort = pabort_reg;
  assign data_abort = dabort_reg;

endmodule

// File: mmuc_pkg.sv
package mmuc_pkg;
  // tlb geometry
  localparam int unsigned ENTRIES = 32;
  localparam logic [4:0] LAST_ENTRY = 5'h1F;
  localparam logic [4:0] LOCK_RESET = 5'h00;
  localparam logic [4:0] RR_RESET = 5'h1F;
  localparam int unsigned TAG_W = 20;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TLB_VA = 8'h04;
  localparam logic [7:0] OFF_TLB_PA = 8'h08;
  localparam logic [7:0] OFF_TLB_CMD = 8'h0C;
  localparam logic [7:0] OFF_FAULT = 8'h10;
  localparam logic [7:0] OFF_PTRS = 8'h14;
  // control register fields
  localparam int unsigned CTRL_MMU_BIT = 0;
  localparam int unsigned CTRL_ALIGN_BIT = 1;
  localparam int unsigned CTRL_DC_BIT = 2;
  localparam int unsigned CTRL_IC_BIT = 3;
  localparam int unsigned CTRL_MD_LSB = 4;
  localparam logic [31:0] CTRL_MASK = 32'h0000003F;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  // lock translation: bit 0 of the pa register flags a walk fault
  localparam int unsigned PA_FAULT_BIT = 0;
  localparam int unsigned PA_TAG_LSB = 12;
  localparam logic [31:0] VA_RESET = 32'h00000000;
  localparam logic [31:0] PA_RESET = 32'h00000000;
  // fault status fields
  localparam int unsigned FLT_ALIGN_BIT = 0;
  localparam int unsigned FLT_PREFETCH_BIT = 1;
  localparam int unsigned FLT_DATA_BIT = 2;
  localparam int unsigned FLT_LOCK_BIT = 3;
  localparam logic [3:0] FAULT_RESET = 4'h0;
  // tlb commands, written to the command register
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_INV_BOTH = 4'h1,
    CMD_INV_I = 4'h2,
    CMD_INV_D = 4'h3,
    CMD_INV_ENT_I = 4'h4,
    CMD_INV_ENT_D = 4'h5,
    CMD_LOCK_I = 4'h6,
    CMD_LOCK_D = 4'h7,
    CMD_UNLOCK_I = 4'h8,
    CMD_UNLOCK_D = 4'h9
  } mmuc_cmd_t;
  // mini data cache policy field encodings
  localparam logic [1:0] MD_WB_RA = 2'h0;
  localparam logic [1:0] MD_WT_RA = 2'h1;
  localparam logic [1:0] MD_WB_RWA = 2'h2;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // one tlb slot
  typedef struct packed {
    logic valid;
    logic locked;
    logic hole;
    logic [TAG_W-1:0] va;
    logic [TAG_W-1:0] pa;
  } mmuc_entry_t;
  // one data access from the load/store unit
  typedef struct packed {
    logic valid;
    logic store;
    logic swap;
    logic x;
    logic c;
    logic b;
    logic hit;
    logic [1:0] size;
    logic [1:0] addr_lo;
  } mmuc_dacc_t;
  // decoded handling of that access
  typedef struct packed {
    logic cacheable;
    logic bufferable;
    logic write_back;
    logic rw_alloc;
    logic mini;
    logic coalesce;
    logic stall;
    logic unpredictable;
    logic line_fill;
    logic ext_write;
    logic fence;
  } mmuc_dpol_t;
endpackage

// File: mmuc_core_model.sv
`timescale 1ns/10ps
// fetch, load/store and walker side of the core
module mmuc_core_model
  import mmuc_pkg::*;
(
  input wire logic aclk,
  output logic fetch_valid,
  output logic [TAG_W-1:0] fetch_va,
  output logic fetch_c,
  output logic fetch_miss,
  output mmuc_dacc_t dacc,
  output logic [TAG_W-1:0] data_va,
  output logic evict_dirty,
  output logic walk_fill,
  output logic walk_is_data,
  output logic [TAG_W-1:0] walk_va,
  output logic [TAG_W-1:0] walk_pa,
  output logic walk_fault
);
  integer seed = 32'h2EF7; // pattern source for released lines
  // quiet start
  initial begin
    fetch_valid = 1'b0;
    dacc = '0;
    evict_dirty = 1'b0;
    walk_fill = 1'b0;
    walk_fault = 1'b0;
  end
  // strobes drop; fetch_va, dacc and evict_dirty get fresh random values
  task idle;
    @(posedge aclk);
    fetch_valid <= 1'b0;
    walk_fill <= 1'b0;
    walk_fault <= 1'b0;
    fetch_va <= 20'($random(seed));
    dacc <= {1'b0, 10'($random(seed))};
    evict_dirty <= 1'($random(seed));
  endtask
  // one code fetch
  task fetch(input logic [19:0] va, input logic c, input logic m);
    @(posedge aclk);
    fetch_valid <= 1'b1;
    fetch_va <= va;
    fetch_c <= c;
    fetch_miss <= m;
    idle;
  endtask
  // one data access
  task data(input mmuc_dacc_t a);
    @(posedge aclk);
    dacc <= a;
    data_va <= 20'($random(seed));
    idle;
  endtask
  // one walker result, fill or fault
  task walk(input logic d, input logic [19:0] va, pa, input logic f);
    @(posedge aclk);
    walk_fill <= !f;
    walk_fault <= f;
    walk_is_data <= d;
    walk_va <= va;
    walk_pa <= pa;
    idle;
  endtask
endmodule

// File: mmuc_checker.sv
`timescale 1ns/10ps
// port-level checks on the core side and read channel
module mmuc_checker
  import mmuc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic fetch_valid,
  input wire logic fetch_c,
  input wire logic fetch_miss,
  input wire logic fetch_cacheable,
  input wire logic icache_fill,
  input wire mmuc_dacc_t dacc,
  input wire mmuc_dpol_t dpol,
  input wire logic evict_dirty,
  input wire logic wb_write,
  input wire logic walk_fault,
  input wire logic walk_is_data,
  input wire logic prefetch_abort,
  input wire logic data_abort
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_fc;
    $past(fetch_valid && fetch_c) |-> fetch_cacheable;
  endproperty
  a_fc: assert property (p_fc) else $error("cacheable fetch lost");
  property p_fill;
    icache_fill |-> fetch_cacheable && $past(fetch_valid && fetch_miss);
  endproperty
  a_fill: assert property (p_fill) else $error("bad icache fill");
  property p_idle;
    !$past(dacc.valid) |-> dpol == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("policy without access");
  property p_fence;
    $past(dacc.valid && !dacc.store && !dacc.swap && !dacc.c
      && (!dacc.x || dacc.b)) |-> dpol.fence;
  endproperty
  a_fence: assert property (p_fence) else $error("load not fenced");
  property p_stall;
    $past(dacc.valid && !dacc.x && !dacc.c && !dacc.b)
      |-> dpol.stall && dpol.fence && !dpol.bufferable;
  endproperty
  a_stall: assert property (p_stall) else $error("no stall");
  property p_coal;
    dpol.coalesce |-> !$past(dacc.x && !dacc.c && dacc.b);
  endproperty
  a_coal: assert property (p_coal) else $error("coalesced");
  property p_cach;
    dpol.cacheable |-> $past(dacc.c);
  endproperty
  a_cach: assert property (p_cach) else $error("cached without c");
  property p_wb;
    wb_write == $past(evict_dirty);
  endproperty
  a_wb: assert property (p_wb) else $error("write-back mismatch");
  property p_pab;
    prefetch_abort |-> $past(walk_fault && !walk_is_data);
  endproperty
  a_pab: assert property (p_pab) else $error("bad prefetch abort");
  property p_rd;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd: assert property (p_rd) else $error("read data dropped");
  c_fence: cover property (dpol.fence);
  c_fill: cover property (icache_fill);
  c_dab: cover property (data_abort);
endmodule

bind mmuc_top mmuc_checker chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .fetch_valid(fetch_valid), .fetch_c(fetch_c),
  .fetch_miss(fetch_miss), .fetch_cacheable(fetch_cacheable),
  .icache_fill(icache_fill), .dacc(dacc), .dpol(dpol),
  .evict_dirty(evict_dirty), .wb_write(wb_write), .walk_fault(walk_fault),
  .walk_is_data(walk_is_data), .prefetch_abort(prefetch_abort),
  .data_abort(data_abort));

// File: mmuc_top_test.sv
`timescale 1ns/10ps
module mmuc_top_test
  import mmuc_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, pv = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic fetch_valid, fetch_c, fetch_miss, evict_dirty, walk_fill;
  logic walk_is_data, walk_fault, itlb_hit, fetch_cacheable, icache_fill;
  logic wb_write, prefetch_abort, data_abort;
  logic [TAG_W-1:0] fetch_va, data_va, walk_va, walk_pa, itlb_pa;
  mmuc_dacc_t dacc;
  mmuc_dpol_t dpol;
  integer num_errors = 0, tests_run = 0;
  integer seed = 32'h2EF7;
  logic [33:0] aq[$]; // expected {resp, data} per bus answer
  logic [69:0] cq[$]; // expected {mask, value} per core answer
  mmuc_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fetch_valid(fetch_valid), .fetch_va(fetch_va),
    .fetch_c(fetch_c), .fetch_miss(fetch_miss), .itlb_hit(itlb_hit),
    .itlb_pa(itlb_pa), .fetch_cacheable(fetch_cacheable),
    .icache_fill(icache_fill),
    .dacc(dacc), .data_va(data_va), .evict_dirty(evict_dirty), .dtlb_hit(),
    .dtlb_pa(), .dpol(dpol), .wb_write(wb_write), .walk_fill(walk_fill),
    .walk_is_data(walk_is_data), .walk_va(walk_va), .walk_pa(walk_pa),
    .walk_fault(walk_fault), .prefetch_abort(prefetch_abort),
    .data_abort(data_abort));
  mmuc_core_model core_u (.aclk(aclk), .fetch_valid(fetch_valid),
    .fetch_va(fetch_va), .fetch_c(fetch_c), .fetch_miss(fetch_miss),
    .dacc(dacc), .data_va(data_va), .evict_dirty(evict_dirty),
    .walk_fill(walk_fill), .walk_is_data(walk_is_data), .walk_va(walk_va),
    .walk_pa(walk_pa), .walk_fault(walk_fault));
  // free-running clock
  initial begin
    forever #4 aclk = ~aclk;
  end
  // counts, verdict, stop
  task end_sim;
    $display("mismatches %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // a wait that ran out
  task tmo(input int n);
    if (n >= 40) begin
      num_errors++;
      $display("[FAIL] %0t bus answer missing", $time);
      end_sim;
    end
  endtask
  // bus answers
  task cmp_bus(input logic [33:0] g);
    logic [33:0] e;
    e = aq.pop_front();
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t bus got %h want %h", $time, g, e);
    end
  endtask
  // core answers, masked
  task cmp_core(input logic [34:0] g);
    logic [69:0] e;
    e = cq.pop_front();
    tests_run++;
    if ((g & e[69:35]) !== e[34:0]) begin
      num_errors++;
      $display("[FAIL] %0t core got %h want %h", $time, g, e[34:0]);
    end
  endtask
  // watcher: oldest note against each answer
  always @(posedge aclk) begin
    if (bvalid && bready)
      cmp_bus({bresp, 32'h0});
    if (rvalid && rready)
      cmp_bus({rresp, rdata});
    if (pv)
      cmp_core({itlb_pa, itlb_hit, fetch_cacheable, icache_fill,
        data_abort, dpol});
    pv <= fetch_valid | dacc.valid;
  end
  // register write, address and data offered together
  task wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r = RESP_OKAY);
    int n;
    aq.push_back({r, 32'h0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 40);
    bready <= 1'b0;
    tmo(n);
  endtask
  // register read
  task rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    aq.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'($random(seed));
    n = 0;
    do begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        rready <= 1'b1;
      n++;
    end while (!(rvalid && rready) && n < 40);
    rready <= 1'b0;
    tmo(n);
  endtask
  // fetch with icache miss; e and mk are {hit, cacheable, fill}
  task fchk(input logic [19:0] va, input logic c, input logic [2:0] e, mk,
    input logic [19:0] p = 20'h00000);
    cq.push_back({{20{e[2]}}, mk, 12'h0, p, e, 12'h0});
    core_u.fetch(va, c, 1'b1);
  endtask
  // data access with attributes k = {x, c, b, store}
  task dchk(input logic mm, input logic [3:0] k);
    mmuc_dacc_t a;
    mmuc_dpol_t e, mk;
    logic x, c, b, st, ab;
    a = 11'($random(seed));
    a.valid = 1'b1;
    a.swap = 1'b0;
    {a.x, a.c, a.b, a.store} = k;
    if (a.size == 2'h3)
      a.size = 2'h2;
    x = mm & k[3];
    c = mm & k[2];
    b = mm & k[1];
    st = k[0];
    e = '0;
    mk = '0;
    {mk.fence, mk.stall, mk.line_fill, mk.ext_write} = 4'hF;
    e.fence = (!st && !c) || (st && x && !c && b) ||
      (!x && !c && !b);
    e.stall = !x && !c && !b;
    e.line_fill = mm && c && !a.hit && (!st || (x && b));
    e.ext_write = st && (!c || (!x && !b) || !mm);
    ab = (a.size == 2'h1 && a.addr_lo[0]) ||
      (a.size == 2'h2 && a.addr_lo != 2'h0);
    cq.push_back({20'h0, 4'h1, mk, 20'h0, 3'h0, ab, e});
    core_u.data(a);
  endtask
  function logic [31:0] ptrs(input logic [4:0] il, ir);
    return {9'h0, 5'h00, 3'h0, RR_RESET, il, ir};
  endfunction
  // main sequence
  initial begin
    logic mm;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(OFF_CTRL, {RESP_OKAY, CTRL_RESET});
    rd(OFF_PTRS, {RESP_OKAY, ptrs(LOCK_RESET, RR_RESET)});
    rd(8'h18, {RESP_SLVERR, 32'h0});
    wr(8'h18, 32'h1, RESP_SLVERR);
    for (int m = 0; m < 2; m++) begin
      mm = m[0];
      wr(OFF_CTRL, {26'h0, MD_WB_RA, 1'b1, mm, 1'b1, mm});
      fchk(20'h00010, 1'b0, {1'b0, !mm, !mm}, 3'h3);
      for (int k = 0; k < 16; k++)
        if (k / 2 != 4)
          dchk(mm, 4'(k));
    end
    wr(OFF_TLB_CMD, 32'(CMD_INV_BOTH));
    wr(OFF_TLB_VA, 32'h12345000);
    wr(OFF_TLB_PA, 32'h0ABCD000);
    wr(OFF_TLB_CMD, 32'(CMD_LOCK_I));
    core_u.walk(1'b0, 20'h00002, 20'h00022, 1'b0);
    core_u.walk(1'b0, 20'h00003, 20'h00033, 1'b0);
    rd(OFF_PTRS, {RESP_OKAY, ptrs(5'h01, 5'h02)});
    fchk(20'h12345, 1'b1, 3'h4, 3'h4, 20'h0ABCD);
    wr(OFF_TLB_CMD, 32'(CMD_INV_I));
    fchk(20'h12345, 1'b1, 3'h4, 3'h4, 20'h0ABCD);
    fchk(20'h00003, 1'b1, 3'h0, 3'h4);
    wr(OFF_TLB_CMD, 32'(CMD_INV_ENT_I));
    fchk(20'h12345, 1'b1, 3'h0, 3'h4);
    wr(OFF_TLB_CMD, 32'(CMD_UNLOCK_I));
    wr(OFF_TLB_CMD, 32'(CMD_INV_I));
    for (int i = 0; i < 32; i++) begin
      wr(OFF_TLB_VA, {12'h0, 8'(i), 12'h0});
      wr(OFF_TLB_CMD, 32'(CMD_LOCK_I));
    end
    rd(OFF_PTRS, {RESP_OKAY, ptrs(5'h1F, 5'h1F)});
    wr(OFF_FAULT, 32'h0000000F);
    wr(OFF_TLB_PA, 32'h00000001);
    wr(OFF_TLB_CMD, 32'(CMD_LOCK_D));
    rd(OFF_FAULT, {RESP_OKAY, 32'h00000008});
    core_u.walk(1'b0, 20'h00005, 20'h00005, 1'b1);
    rd(OFF_FAULT, {RESP_OKAY, 32'h0000000A});
    end_sim;
  end
endmodule
